// [core/tba_pkg.sv]
// shared constants and types of the target bus access arbiter
package tba_pkg;

	// ====================================================================
	// bus masters and targets
	localparam int          NMST     = 3;
	localparam int          NTGT     = 4;
	localparam int          TGT_W    = 2;
	localparam int          ADDR_W   = 23;
	localparam int          M_CPU    = 0;
	localparam int          M_DBG    = 1;
	localparam int          M_IOC    = 2;
	localparam logic [TGT_W-1:0] TGT_EXT = 2'h3;

	// ====================================================================
	// port replacement register window, global address
	localparam logic [ADDR_W-1:0] PRR_LO = 23'h000000;
	localparam logic [ADDR_W-1:0] PRR_HI = 23'h00003F;

	// ====================================================================
	// reset values
	localparam logic [NMST-1:0] GNT_RST = 3'h0;

	typedef logic [ADDR_W-1:0] tba_addr_t;
	typedef logic [TGT_W-1:0]  tba_tgt_t;

	// true when addr lies within [lo, hi]
	function automatic logic tba_in_range(input tba_addr_t addr, input tba_addr_t lo, input tba_addr_t hi);
		tba_in_range = (addr >= lo) && (addr <= hi);
	endfunction : tba_in_range

endpackage : tba_pkg

// [core/tba_arb_if.sv]
// request and grant vectors between the arbiter top and its priority core
`timescale 1ns/1ps
interface tba_arb_if;
	import tba_pkg::*;

	logic [NMST-1:0][NTGT-1:0] req;
	logic                      prr_stall;
	logic [NMST-1:0][NTGT-1:0] gnt;

	modport ctl (output req, output prr_stall, input gnt);
	modport arb (input req, input prr_stall, output gnt);
endinterface : tba_arb_if

// [core/tba_prio_core.sv]
// fixed-priority grant logic, one slice per target bus
`timescale 1ns/1ps
module tba_prio_core
	import tba_pkg::*;
(
	// request and grant vectors
	tba_arb_if.arb bus
);

	// ====================================================================
	// per-target priority: cpu, then debug master, then coprocessor
	genvar t;
	generate
		for (t = 0; t < NTGT; t++) begin : g_tgt
			wire cpu_r = bus.req[M_CPU][t];
			wire dbg_r = bus.req[M_DBG][t];
			wire ioc_r = bus.req[M_IOC][t];
			// port replacement access stalls cpu and debug master everywhere
			assign bus.gnt[M_CPU][t] = cpu_r & ~bus.prr_stall;
			assign bus.gnt[M_DBG][t] = dbg_r & ~cpu_r & ~bus.prr_stall;
			// coprocessor loses to cpu and debug unless it is the prr access
			assign bus.gnt[M_IOC][t] = ioc_r & (bus.prr_stall | (~cpu_r & ~dbg_r));
		end
	endgenerate

endmodule : tba_prio_core

// [core/tba_arbiter.sv]
// target bus access arbiter for cpu, debug master and i/o coprocessor
`timescale 1ns/1ps
// What this block does
// - at most one master connected to any target bus per cycle.
// - cpu wins over the i/o coprocessor on the same target.
// - debug master wins over the i/o coprocessor on the same target.
// - coprocessor port replacement access always granted; cpu and debug stalled meanwhile.
// - in emulation mode every internal access is mirrored on the external bus.
// - external bus reserved while a port replacement access runs.
// - cpu write into protected coprocessor ram raises access violation interrupt.
module tba_arbiter
	import tba_pkg::*;
(
	// clock and reset
	input  wire  logic                          clock,
	input  wire  logic                          resetn,
	// master requests, index 0 cpu, 1 debug master, 2 i/o coprocessor
	input  wire  logic [NMST-1:0]               m_req,
	input  wire  logic [NMST-1:0][TGT_W-1:0]    m_tgt,
	input  wire  logic [NMST-1:0][ADDR_W-1:0]   m_addr,
	input  wire  logic [NMST-1:0]               m_we,
	// grants, one cycle per access
	output logic       [NMST-1:0]               m_gnt_q,
	output logic       [NMST-1:0][TGT_W-1:0]    m_gnt_tgt_q,
	// mode and protected region
	input  wire  logic                          emul_mode,
	input  wire  logic [ADDR_W-1:0]             prot_lo,
	input  wire  logic [ADDR_W-1:0]             prot_hi,
	// external bus visibility
	output logic       [NMST-1:0]               ext_vis_valid_q,
	output logic       [NMST-1:0][ADDR_W-1:0]   ext_vis_addr_q,
	output logic       [NMST-1:0]               ext_vis_we_q,
	output logic                                ext_reserved_q,
	// interrupt toward the cpu
	output logic                                cpu_viol_irq_q
);

	// ====================================================================
	// request decode
	tba_arb_if arb_bus ();

	logic [NMST-1:0] live_req;
	logic            ioc_in_prr;
	logic            ioc_prr_req;
	logic            ioc_prr_held;
	logic            prr_stall;
	logic [NMST-1:0] gnt_d;
	logic            viol_d;

	// a master is not re-granted in the cycle its grant stands
	assign live_req    = m_req & ~m_gnt_q;
	// coprocessor address lies in the port replacement window
	assign ioc_in_prr   = tba_in_range(m_addr[M_IOC], PRR_LO, PRR_HI);
	assign ioc_prr_req  = live_req[M_IOC] & ioc_in_prr;
	// the granted prr access keeps the stall through its grant cycle
	assign ioc_prr_held = m_gnt_q[M_IOC] & ioc_in_prr;
	// stall covers the request cycle and the grant cycle of the prr access
	assign prr_stall    = ioc_prr_req | ioc_prr_held;

	// request vectors for the priority core, one bit per master and target
	// a master asks for target t when its live request points there
	genvar m, t;
	generate
		for (m = 0; m < NMST; m++) begin : g_mst
			for (t = 0; t < NTGT; t++) begin : g_t
				assign arb_bus.req[m][t] = live_req[m] & (m_tgt[m] == TGT_W'(t));
			end
			// a master is granted when any target slice grants it
			assign gnt_d[m] = |arb_bus.gnt[m];
		end
	endgenerate

	// the stall reaches every target slice of the core
	assign arb_bus.prr_stall = prr_stall;

	// cpu before debug master is a fixed house order, resolved per target
	tba_prio_core u_core (
		.bus (arb_bus.arb)
	);

	// cpu write landing in the coprocessor's protected ram
	// the access is still granted; only the pulse marks it
	assign viol_d = gnt_d[M_CPU] & m_we[M_CPU] & tba_in_range(m_addr[M_CPU], prot_lo, prot_hi);

	// ====================================================================
	// grant registers
	// the target is copied every cycle; it only matters with the grant
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			m_gnt_q     <= GNT_RST;
			m_gnt_tgt_q <= '0;
		end else begin
			m_gnt_q     <= gnt_d;
			m_gnt_tgt_q <= m_tgt;
		end
	end

	// external bus mirror and reservation
	// address and direction follow every cycle; valid marks the access
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ext_vis_valid_q <= '0;
			ext_vis_addr_q  <= '0;
			ext_vis_we_q    <= '0;
			ext_reserved_q  <= 1'b0;
		end else begin
			ext_vis_valid_q <= emul_mode ? gnt_d : '0;
			ext_vis_addr_q  <= m_addr;
			ext_vis_we_q    <= m_we;
			ext_reserved_q  <= prr_stall;
		end
	end

	// access violation pulse
	// a pulse, not a flag: any sticky state lives on the cpu side
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cpu_viol_irq_q <= 1'b0;
		end else begin
			cpu_viol_irq_q <= viol_d;
		end
	end

	// ====================================================================
	// assertions
	// a grant that lands on the external bus
	logic [NMST-1:0] gnt_ext;
	generate
		for (m = 0; m < NMST; m++) begin : g_ext
			assign gnt_ext[m] = m_gnt_q[m] & (m_gnt_tgt_q[m] == TGT_EXT);
		end
	endgenerate

	// all checks run on the bus clock and rest during reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	chk_one_per_target: assert property (
		!(m_gnt_q[M_CPU] && m_gnt_q[M_IOC] && m_gnt_tgt_q[M_CPU] == m_gnt_tgt_q[M_IOC]) &&
		!(m_gnt_q[M_CPU] && m_gnt_q[M_DBG] && m_gnt_tgt_q[M_CPU] == m_gnt_tgt_q[M_DBG]) &&
		!(m_gnt_q[M_DBG] && m_gnt_q[M_IOC] && m_gnt_tgt_q[M_DBG] == m_gnt_tgt_q[M_IOC]))
		else $error("two masters granted on one target");
	chk_cpu_over_ioc: assert property (
		live_req[M_CPU] && live_req[M_IOC] && m_tgt[M_CPU] == m_tgt[M_IOC] && !prr_stall
		|=> m_gnt_q[M_CPU] && !m_gnt_q[M_IOC])
		else $error("cpu did not win over coprocessor");
	chk_dbg_over_ioc: assert property (
		live_req[M_DBG] && live_req[M_IOC] && m_tgt[M_DBG] == m_tgt[M_IOC] && !live_req[M_CPU] && !prr_stall
		|=> m_gnt_q[M_DBG] && !m_gnt_q[M_IOC])
		else $error("debug master did not win over coprocessor");
	chk_prr_grant: assert property (
		ioc_prr_req |=> m_gnt_q[M_IOC] && !m_gnt_q[M_CPU] && !m_gnt_q[M_DBG])
		else $error("prr access not granted alone");
	chk_emul_mirror: assert property (
		m_gnt_q[M_CPU] && $past(emul_mode) |-> ext_vis_valid_q[M_CPU] &&
		ext_vis_addr_q[M_CPU] == $past(m_addr[M_CPU]))
		else $error("cpu access not mirrored in emulation mode");
	chk_ext_reserved: assert property (
		ext_reserved_q |-> !gnt_ext[M_CPU] && !gnt_ext[M_DBG])
		else $error("external bus used while reserved");
	chk_prr_reserve: assert property (
		ioc_prr_req |=> ext_reserved_q [*2])
		else $error("reservation missing during prr access");
	chk_viol_irq: assert property (
		live_req[M_CPU] && m_we[M_CPU] && !prr_stall && m_addr[M_CPU] >= prot_lo && m_addr[M_CPU] <= prot_hi
		|=> cpu_viol_irq_q ##1 !cpu_viol_irq_q)
		else $error("violation interrupt not raised once");
	chk_cpu_over_dbg: assert property (
		live_req[M_CPU] && live_req[M_DBG] && m_tgt[M_CPU] == m_tgt[M_DBG] && !prr_stall
		|=> m_gnt_q[M_CPU] && !m_gnt_q[M_DBG])
		else $error("debug master beat cpu");
	chk_no_mirror_off: assert property (
		!$past(emul_mode) |-> ext_vis_valid_q == '0)
		else $error("mirror active outside emulation mode");

	// ====================================================================
	// further checks: stall, interrupt cause, reservation release
	chk_stall_blocks: assert property (
		prr_stall |=> !m_gnt_q[M_CPU] && !m_gnt_q[M_DBG])
		else $error("cpu or debug master granted during prr access");
	chk_irq_cause: assert property (
		cpu_viol_irq_q |-> m_gnt_q[M_CPU] && $past(m_we[M_CPU]) &&
		$past(m_addr[M_CPU]) >= $past(prot_lo) && $past(m_addr[M_CPU]) <= $past(prot_hi))
		else $error("violation interrupt without a protected cpu write");
	chk_reserve_ends: assert property (
		!ioc_prr_req && !m_gnt_q[M_IOC] |=> !ext_reserved_q)
		else $error("reservation held after prr access");

	// one grant at most on each target bus
	generate
		for (t = 0; t < NTGT; t++) begin : g_chk_tgt
			logic [NMST-1:0] on_tgt;
			for (m = 0; m < NMST; m++) begin : g_on
				assign on_tgt[m] = m_gnt_q[m] & (m_gnt_tgt_q[m] == TGT_W'(t));
			end
			chk_tgt_exclusive: assert property ($onehot0(on_tgt))
				else $error("target bus shared by two masters");
		end
	endgenerate

	// grant shape and mirror channel of every master
	generate
		for (m = 0; m < NMST; m++) begin : g_chk_mst
			chk_grant_pulse: assert property (
				m_gnt_q[m] |=> !m_gnt_q[m])
				else $error("grant held longer than one cycle");
			chk_grant_asked: assert property (
				m_gnt_q[m] |-> $past(m_req[m]) && m_gnt_tgt_q[m] == $past(m_tgt[m]))
				else $error("grant without a matching request");
			chk_mirror_chan: assert property (
				m_gnt_q[m] && $past(emul_mode) |-> ext_vis_valid_q[m] &&
				ext_vis_addr_q[m] == $past(m_addr[m]) && ext_vis_we_q[m] == $past(m_we[m]))
				else $error("master access not mirrored in emulation mode");
		end
	endgenerate

	cov_contention: cover property (live_req[M_CPU] && live_req[M_IOC] && m_tgt[M_CPU] == m_tgt[M_IOC]);
	cov_dbg_contention: cover property (live_req[M_DBG] && live_req[M_IOC] && m_tgt[M_DBG] == m_tgt[M_IOC]);
	cov_prr_stall: cover property (ioc_prr_req && live_req[M_CPU]);
	cov_violation: cover property (cpu_viol_irq_q);
	cov_emul_vis: cover property (ext_vis_valid_q[M_IOC]);

endmodule : tba_arbiter

// [test/tba_master_model.sv]
// model of the three bus masters facing the arbiter
`timescale 1ns/1ps
module tba_master_model
	import tba_pkg::*;
(
	// clock, reset and bench commands {target, address, write}
	input  logic                            clock,
	input  logic                            resetn,
	input  logic [NMST-1:0]                 go,
	input  logic [NMST-1:0][TGT_W+ADDR_W:0] go_cmd,
	// arbiter side
	input  logic [NMST-1:0]                 gnt,
	output logic [NMST-1:0]                 req_q,
	output logic [NMST-1:0][TGT_W-1:0]      tgt_q,
	output logic [NMST-1:0][ADDR_W-1:0]     addr_q,
	output logic [NMST-1:0]                 we_q
);
	// hold each access until granted, then drop it and scramble the stale address
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
			{req_q, tgt_q, addr_q, we_q} <= '0;
		else
			for (int i = 0; i < NMST; i++)
				if (req_q[i] && gnt[i])
					{req_q[i], addr_q[i]} <= {1'b0, ~addr_q[i]};
				else if (go[i] && !req_q[i])
					{req_q[i], tgt_q[i], addr_q[i], we_q[i]} <= {1'b1, go_cmd[i]};
endmodule : tba_master_model

// [test/testbench.sv]
// self-checking bench of the target bus access arbiter
`timescale 1ns/1ps
module testbench
	import tba_pkg::*; ;
	logic                            clock = 1'b0, resetn = 1'b0, emul = 1'b0, vis_we = 1'b0, rsv, irq;
	logic [NMST-1:0]                 go = '0, req, we, gnt, vv, vw;
	logic [NMST-1:0][TGT_W-1:0]      tgt, gt, gtg;
	logic [NMST-1:0][ADDR_W-1:0]     addr, va;
	logic [NMST-1:0][TGT_W+ADDR_W:0] cmd = '0;
	int                              bad_count, n_tests, cyc, irq_n, rsv_n, vis_n, gc[NMST];
	// 100 ns clock
	initial forever #50 clock = ~clock;
	tba_arbiter dut (.clock(clock), .resetn(resetn), .m_req(req), .m_tgt(tgt), .m_addr(addr), .m_we(we),
		.m_gnt_q(gnt), .m_gnt_tgt_q(gt), .emul_mode(emul), .prot_lo(23'h001000), .prot_hi(23'h001FFF),
		.ext_vis_valid_q(vv), .ext_vis_addr_q(va), .ext_vis_we_q(vw), .ext_reserved_q(rsv), .cpu_viol_irq_q(irq));
	tba_master_model mst (.clock(clock), .resetn(resetn), .go(go), .go_cmd(cmd), .gnt(gnt), .req_q(req),
		.tgt_q(tgt), .addr_q(addr), .we_q(we));
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("%0d checks, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic issue(input logic [NMST-1:0] m, input logic [NMST-1:0][TGT_W+ADDR_W:0] c);
		go  <= m;
		cmd <= c;
		@(posedge clock);
		go <= '0;
		for (int k = 0; k < 20 && (k < 3 || req !== '0); k++)
			@(posedge clock);
	endtask : issue
	// grant cycle of each master, pulse counts
	always @(posedge clock) begin
		cyc   <= cyc + 1;
		irq_n <= irq_n + int'(irq);
		rsv_n <= rsv_n + int'(rsv);
		for (int i = 0; i < NMST; i++) begin
			if (gnt[i] === 1'b1) begin
				gc[i]  <= cyc;
				gtg[i] <= gt[i];
			end
			// a mirrored access to the probe address with the expected direction
			if (vv[i] === 1'b1 && va[i] === 23'h001FFF && vw[i] === vis_we)
				vis_n <= vis_n + 1;
		end
	end
	task automatic t_prio();
		issue(3'h5, {3{2'h1, 23'h000200, 1'b0}});
		chk(32'(gc[M_CPU] < gc[M_IOC]), 32'h1);
		chk(32'(gtg[M_CPU]), 32'h1);
		issue(3'h6, {3{2'h2, 23'h000200, 1'b0}});
		chk(32'(gc[M_DBG] < gc[M_IOC]), 32'h1);
		chk(32'(gtg[M_IOC]), 32'h2);
		issue(3'h3, {3{2'h0, 23'h000200, 1'b1}});
		chk(32'(gc[M_CPU] < gc[M_DBG]), 32'h1);
		chk(32'(gtg[M_DBG]), 32'h0);
	endtask : t_prio
	task automatic t_prr();
		int n0;
		n0 = rsv_n;
		issue(3'h7, {2'h2, PRR_HI, 1'b1, 2'h3, 23'h000400, 1'b0, 2'h1, 23'h000400, 1'b0});
		chk(32'(gc[M_IOC] < gc[M_CPU] && gc[M_IOC] < gc[M_DBG]), 32'h1);
		chk(32'(gtg[M_DBG]), 32'h3);
		chk(32'(rsv_n - n0), 32'h2);
	endtask : t_prr
	task automatic t_acc(input logic [NMST-1:0] m, input logic w, em, input logic [31:0] ei, ev);
		int n0, n1;
		n0 = irq_n;
		n1 = vis_n;
		emul <= em;
		vis_we <= w;
		issue(m, {3{2'h0, 23'h001FFF, w}});
		chk(32'(irq_n - n0), ei);
		chk(32'(vis_n - n1), ev);
	endtask : t_acc
	// reset, scenarios and verdict
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		t_prio();
		t_prr();
		t_acc(3'h1, 1'b1, 1'b1, 32'h1, 32'h1);
		t_acc(3'h1, 1'b0, 1'b0, 32'h0, 32'h0);
		t_acc(3'h4, 1'b1, 1'b1, 32'h0, 32'h1);
		final_report();
	end
	// watchdog: the scenarios need well under 300 cycles
	initial begin
		repeat (2000) @(posedge clock);
		bad_count++;
		final_report();
	end
endmodule : testbench
